// >>> bench/fgr_host_model.sv
// I2C controller model standing in for the host processor
`timescale 1ns/1ps
`default_nettype none
module fgr_host_model (
    // Bus lines
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_drv_o
);
    localparam realtime Q = 31.25;
    localparam [6:0] TADDR = 7'b0110110;
    // Clock idles high between frames
    initial begin
        scl_o = 1'b1;
        sda_drv_o = 1'b0;
    end
    task start;
        #Q sda_drv_o = 1'b0;
        #Q scl_o = 1'b1;
        #Q sda_drv_o = 1'b1;
        #Q scl_o = 1'b0;
    endtask
    task stop;
        #Q sda_drv_o = 1'b1;
        #Q scl_o = 1'b1;
        #Q sda_drv_o = 1'b0;
        #Q;
    endtask
    // Ninth bit: released to collect an acknowledge, low to give one
    task xb(input logic [7:0] b, input logic h9, output logic [7:0] r, output logic a);
        logic [8:0] tx;
        logic [8:0] sh;
        tx = {b, h9};
        for (int i = 0; i < 9; i++) begin
            #Q sda_drv_o = ~tx[8 - i];
            #Q scl_o = 1'b1;
            #Q sh = {sh[7:0], sda_i};
            #Q scl_o = 1'b0;
        end
        r = sh[8:1];
        a = sh[0];
    endtask
    task wr_word(input logic [7:0] p, input logic [15:0] w, output logic a);
        logic [7:0] r;
        start;
        xb({TADDR, 1'b0}, 1'b1, r, a);
        xb(p, 1'b1, r, a);
        xb(w[15:8], 1'b1, r, a);
        xb(w[7:0], 1'b1, r, a);
        stop;
    endtask
    task rd_word(input logic [7:0] p, output logic [15:0] w);
        logic [7:0] r;
        logic a;
        start;
        xb({TADDR, 1'b0}, 1'b1, r, a);
        xb(p, 1'b1, r, a);
        start;
        xb({TADDR, 1'b1}, 1'b1, r, a);
        xb(8'hFF, 1'b0, w[15:8], a);
        xb(8'hFF, 1'b1, w[7:0], a);
        stop;
    endtask
endmodule // fgr_host_model
`default_nettype wire

// >>> bench/fgr_regbank_checker.sv
// Port-level assertions for the fuel-gauge register bank
`timescale 1ns/1ps
`default_nettype none
module fgr_regbank_checker #(
    parameter [32:0] VACT_CYC = 33'd200,
    parameter [32:0] VHIB_CYC = 33'd500,
    parameter [32:0] SOC_FIRST_CYC = 33'd100
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // I2C pins
    input wire scl_i,
    input wire sda_oe_o,
    // Control outputs
    input wire alert_output_flag_n_o,
    input wire quick_start_o,
    input wire sleep_en_o,
    input wire sleep_force_o,
    input wire [7:0] reset_voltage_threshold_o,
    input wire por_cmd_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    rst_idle_a: assert property ($past(sys_rst_i) |-> !sda_oe_o
        && alert_output_flag_n_o && !por_cmd_o && !quick_start_o)
        else $error("outputs not idle after reset");
    rst_thresh_a: assert property ($past(sys_rst_i) |-> reset_voltage_threshold_o == 8'h96)
        else $error("threshold output wrong after reset");
    sda_timing_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data line moved while clock high");
    qs_pulse_a: assert property (quick_start_o |=> !quick_start_o [*4])
        else $error("quick start pulse too long");
    qs_cause_a: assert property (quick_start_o |-> !$past(scl_i))
        else $error("quick start outside a write commit");
    sleep_pair_a: assert property (sleep_force_o |-> sleep_en_o)
        else $error("sleep forced without sleep enable");
    por_pulse_a: assert property (por_cmd_o |=> !por_cmd_o)
        else $error("reset command pulse too long");
    por_clear_a: assert property (por_cmd_o |-> alert_output_flag_n_o && !sda_oe_o
        && !sleep_en_o && reset_voltage_threshold_o == 8'h96)
        else $error("outputs not cleared by reset command");
    alert_rel_a: assert property ($rose(alert_output_flag_n_o) |-> !$past(scl_i))
        else $error("alert released outside a write");

    cover property (quick_start_o);
    cover property (por_cmd_o);
    cover property ($fell(alert_output_flag_n_o));
    cover property ($rose(sda_oe_o));
endmodule // fgr_regbank_checker

bind fgr_regbank fgr_regbank_checker #(
    .VACT_CYC(VACT_CYC), .VHIB_CYC(VHIB_CYC), .SOC_FIRST_CYC(SOC_FIRST_CYC)
) u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl_i), .sda_oe_o(sda_oe_o),
    .alert_output_flag_n_o(alert_output_flag_n_o), .quick_start_o(quick_start_o),
    .sleep_en_o(sleep_en_o), .sleep_force_o(sleep_force_o),
    .reset_voltage_threshold_o(reset_voltage_threshold_o), .por_cmd_o(por_cmd_o)
);
`default_nettype wire

// >>> bench/test_fuel_gauge_register_bank.sv
// Self-checking bench for the fuel-gauge register bank
`timescale 1ns/1ps
`default_nettype none
module test_fuel_gauge_register_bank;
    localparam [32:0] VACT = 33'd200;
    localparam [15:0] VER = 16'h2B00; // Arbitrary value
    localparam [7:0] IDV = 8'hA5; // Arbitrary value
    localparam [15:0] ALL = 16'hFFFF;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic hib = 1'b0;
    logic [15:0] pdat = 16'h0000;
    logic [3:0] vld = 4'h0;
    logic scl, drv, oe, so, alert_n, qs, sen, sfc, por, a;
    logic [7:0] thr;
    logic [7:0] r;
    logic [15:0] d;
    int n_fail = 0;
    int n_tests = 0;
    int qs_cnt = 0;
    int por_cnt = 0;
    wire sda = drv ? 1'b0 : (oe ? so : 1'b1);

    always #5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (qs) qs_cnt <= qs_cnt + 1;
        if (por) por_cnt <= por_cnt + 1;
    end

    fgr_host_model HOST (.sda_i(sda), .scl_o(scl), .sda_drv_o(drv));
    fgr_regbank #(.VACT_CYC(VACT), .VHIB_CYC(33'd500), .SOC_FIRST_CYC(33'd100),
        .VERSION_CODE(VER), .IDENT_CODE(IDV)) DUT (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_i(scl), .sda_i(sda), .sda_o(so),
        .sda_oe_o(oe), .adc_data_i(pdat), .adc_valid_i(vld[0]), .soc_i(pdat),
        .soc_valid_i(vld[1]), .charge_rate_estimate_i(pdat), .charge_rate_valid_i(vld[2]),
        .hib_active_i(hib), .reset_voltage_event_i(vld[3]), .alert_output_flag_n_o(alert_n),
        .quick_start_o(qs), .sleep_en_o(sen), .sleep_force_o(sfc),
        .reset_voltage_threshold_o(thr), .por_cmd_o(por));

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Don't-care bits are masked out of the compare
    task rdc(input logic [7:0] p, input logic [15:0] e, input logic [15:0] m);
        HOST.rd_word(p, d);
        chk($sformatf("reg_%h", p), e & m, d & m);
    endtask
    task wr(input logic [7:0] p, input logic [15:0] w);
        HOST.wr_word(p, w, a);
    endtask
    task pulse(input int s, input logic [15:0] v);
        @(posedge clk_i);
        pdat <= v;
        vld <= 4'h1 << s;
        @(posedge clk_i);
        vld <= 4'h0;
    endtask
    task stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task t_reset;
        rdc(8'h0A, 16'h8030, ALL);
        rdc(8'h0C, 16'h971C, ALL);
        rdc(8'h14, 16'h00FF, ALL);
        rdc(8'h1A, 16'h0001, ALL);
        rdc(8'hFE, 16'hFFFF, ALL);
        rdc(8'h18, {8'h96, IDV}, ALL);
        rdc(8'h06, 16'h0000, 16'h1000);
        rdc(8'h08, VER, ALL);
        chk("thr", 16'h0096, {8'h00, thr});
        $display("t_reset finished");
    endtask

    task t_write;
        wr(8'h0A, 16'h1234);
        chk("ack", 16'h0000, {15'h0, a});
        rdc(8'h0A, 16'h1234, ALL);
        wr(8'h18, 16'h77FF);
        rdc(8'h18, {8'h77, IDV}, ALL);
        chk("thr", 16'h0077, {8'h00, thr});
        HOST.start;
        HOST.xb(8'h6C, 1'b1, r, a);
        HOST.xb(8'h14, 1'b1, r, a);
        HOST.xb(8'h55, 1'b1, r, a);
        HOST.stop;
        rdc(8'h14, 16'h00FF, ALL);
        HOST.start;
        HOST.xb(8'h6E, 1'b1, r, a);
        HOST.stop;
        chk("addr_nak", 16'h0001, {15'h0, a});
        wr(8'h06, 16'h6000);
        chk("qs_cnt", 16'h0001, qs_cnt[15:0]);
        chk("sleep_en", 16'h0001, {15'h0, sen});
        wr(8'h0C, 16'h979C);
        chk("sleep_force", 16'h0001, {15'h0, sfc});
        wr(8'h0C, 16'h973C);
        chk("alert_n", 16'h0000, {15'h0, alert_n});
        wr(8'h0C, 16'h971C);
        chk("alert_n", 16'h0001, {15'h0, alert_n});
        wr(8'h06, 16'h0000);
        chk("sleep_en", 16'h0000, {15'h0, sen});
        rdc(8'h10, 16'h0000, ALL);
        $display("t_write finished");
    endtask

    task t_meas;
        wr(8'h1A, 16'h0000);
        pulse(3, 16'h0000);
        for (int i = 0; i < 4; i++) pulse(0, {12'h400, i[1:0], 2'b00});
        repeat (VACT + 33'd20) @(posedge clk_i);
        wr(8'h02, 16'h0000);
        rdc(8'h02, 16'h4006, ALL);
        pulse(2, 16'h0123);
        wr(8'h16, 16'hFFFF);
        rdc(8'h16, 16'h0123, ALL);
        rdc(8'h1A, 16'h0008, ALL);
        chk("alert_n", 16'h0001, {15'h0, alert_n});
        @(posedge clk_i);
        hib <= 1'b1;
        rdc(8'h06, 16'h1000, 16'h1000);
        @(posedge clk_i);
        hib <= 1'b0;
        wr(8'h14, 16'h0010);
        repeat (VACT + 33'd20) @(posedge clk_i);
        chk("alert_n", 16'h0000, {15'h0, alert_n});
        rdc(8'h1A, 16'h000A, ALL);
        wr(8'h14, 16'h00FF);
        repeat (VACT + 33'd20) @(posedge clk_i);
        wr(8'h1A, 16'h0000);
        wr(8'h0C, 16'h971C);
        chk("alert_n", 16'h0001, {15'h0, alert_n});
        rdc(8'h1A, 16'h0000, ALL);
        $display("t_meas finished");
    endtask

    task t_por;
        wr(8'hFE, 16'h5400);
        chk("por_nak", 16'h0001, {15'h0, a});
        chk("por_cnt", 16'h0001, por_cnt[15:0]);
        pulse(1, 16'h1111);
        repeat (150) @(posedge clk_i);
        rdc(8'h04, 16'h0000, ALL);
        rdc(8'h0A, 16'h8030, ALL);
        rdc(8'h1A, 16'h0001, ALL);
        chk("thr", 16'h0096, {8'h00, thr});
        pulse(1, 16'h3280);
        rdc(8'h04, 16'h3280, ALL);
        // Falling past the 4% empty threshold raises the low-charge flag
        pulse(1, 16'h0500);
        pulse(1, 16'h0300);
        rdc(8'h1A, 16'h0011, ALL);
        chk("alert_n", 16'h0000, {15'h0, alert_n});
        $display("t_por finished");
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        t_reset;
        t_write;
        t_meas;
        t_por;
        stop_test;
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        n_fail++;
        $display("Error run_time expected end seen timeout");
        stop_test;
    end
endmodule // test_fuel_gauge_register_bank
`default_nettype wire

// >>> rtl/fgr_regbank.v
// Fuel-gauge register bank behind an I2C target port
`timescale 1ns/1ps
`default_nettype none
`include "fgr_map.vh"

module fgr_regbank #(
    parameter [32:0] VACT_CYC = `FGR_VACT_MS * (`FGR_CLK_HZ / 33'd1000),
    parameter [32:0] VHIB_CYC = `FGR_VHIB_S * `FGR_CLK_HZ,
    parameter [32:0] SOC_FIRST_CYC = `FGR_SOC_FIRST_S * `FGR_CLK_HZ,
    parameter [15:0] VERSION_CODE = 16'h0042, // Arbitrary value
    parameter [7:0] IDENT_CODE = 8'h5A // Arbitrary value
) (
    // Clock and reset
    input wire clk_i,
    input wire sys_rst_i,
    // I2C pins
    input wire scl_i,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe_o,
    // Measurement core
    input wire [15:0] adc_data_i,
    input wire adc_valid_i,
    input wire [15:0] soc_i,
    input wire soc_valid_i,
    input wire [15:0] charge_rate_estimate_i,
    input wire charge_rate_valid_i,
    input wire hib_active_i,
    input wire reset_voltage_event_i,
    // Control outputs
    output reg alert_output_flag_n_o,
    output reg quick_start_o,
    output reg sleep_en_o,
    output reg sleep_force_o,
    output reg [7:0] reset_voltage_threshold_o,
    output reg por_cmd_o
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_RX = 3'h1;
    localparam [2:0] ST_ACK = 3'h2;
    localparam [2:0] ST_TX = 3'h3;
    localparam [2:0] ST_RACK = 3'h4;
    localparam [2:0] ST_NEXT = 3'h5;
    localparam [1:0] K_ADDR = 2'h0;
    localparam [1:0] K_PTR = 2'h1;
    localparam [1:0] K_DATA = 2'h2;

    // Pin synchronisers
    reg scl_m_r, scl_s_r, scl_d_r;
    reg sda_m_r, sda_s_r, sda_d_r;
    wire rst_all;
    wire scl_rise;
    wire scl_fall;
    wire i2c_start;
    wire i2c_stop;

    // Transfer state
    reg [2:0] st_r;
    reg [1:0] kind_r;
    reg [3:0] cnt_r;
    reg [7:0] shift_r;
    reg [7:0] txs_r;
    reg [7:0] ptr_r;
    reg [7:0] hi_r;
    reg hi_ok_r;
    reg rw_r;
    reg lo_sel_r;
    reg [15:0] rd_word_r;
    reg wr_stb_r;
    reg [7:0] wr_addr_r;
    reg [15:0] wr_data_r;
    reg por_hit_r;

    // Registers
    reg [15:0] cellv_r, soc_r, rate_r;
    reg [15:0] mode_r, hibthr_r, setup_r, vwin_r, stat_r, cmd_r;
    reg [7:0] vrst_r;
    reg [15:0] tbl_r [0:31];
    reg [15:0] rd_word;

    // Measurement state
    reg [17:0] acc_r;
    reg [1:0] nacc_r;
    reg [15:0] avg_r;
    reg avg_ok_r;
    reg [32:0] vtick_r;
    reg [32:0] boot_r;
    reg soc_ok_r;
    reg [7:0] soc_ref_r;
    reg [15:0] stat_set;
    reg [15:0] stat_nxt;
    reg [15:0] setup_nxt;
    wire [7:0] hd_thr;
    wire [32:0] vper;

    assign rst_all = sys_rst_i | por_hit_r;
    assign scl_rise = scl_s_r & ~scl_d_r;
    assign scl_fall = ~scl_s_r & scl_d_r;
    assign i2c_start = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
    assign i2c_stop = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
    assign hd_thr = 8'd32 - {3'h0, setup_r[4:0]};
    assign vper = hib_active_i ? VHIB_CYC : VACT_CYC;

    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_m_r <= scl_i;
            scl_s_r <= scl_m_r;
            scl_d_r <= scl_s_r;
            sda_m_r <= sda_i;
            sda_s_r <= sda_m_r;
            sda_d_r <= sda_s_r;
        end
    end

    // Read mux; unmapped and write-only words read zero
    always @* begin
        case (ptr_r)
            `FGR_OFS_CELLV: rd_word = cellv_r;
            `FGR_OFS_SOC: rd_word = soc_r;
            `FGR_OFS_MODE: rd_word = {3'h0, hib_active_i, 12'h000};
            `FGR_OFS_VER: rd_word = VERSION_CODE;
            `FGR_OFS_HIBTHR: rd_word = hibthr_r;
            `FGR_OFS_SETUP: rd_word = setup_r;
            `FGR_OFS_VWIN: rd_word = vwin_r;
            `FGR_OFS_RATE: rd_word = rate_r;
            `FGR_OFS_VRST: rd_word = {vrst_r, IDENT_CODE};
            `FGR_OFS_STAT: rd_word = stat_r;
            `FGR_OFS_CMDW: rd_word = cmd_r;
            default: rd_word = 16'h0000;
        endcase
    end

    // Command reset lives outside the reset it causes
    always @(posedge clk_i) begin
        if (sys_rst_i) begin
            por_hit_r <= 1'b0;
            por_cmd_o <= 1'b0;
        end else begin
            por_hit_r <= 1'b0;
            if (st_r == ST_RX && kind_r == K_DATA && scl_fall && cnt_r == 4'h8 && hi_ok_r
                && ptr_r == `FGR_OFS_CMDW && {hi_r, shift_r} == `FGR_POR_KEY) begin
                por_hit_r <= 1'b1;
            end
            por_cmd_o <= por_hit_r;
        end
    end

    // I2C target engine
    always @(posedge clk_i) begin
        if (rst_all) begin
            st_r <= ST_IDLE;
            kind_r <= K_ADDR;
            cnt_r <= 4'h0;
            shift_r <= 8'h00;
            txs_r <= 8'h00;
            ptr_r <= 8'h00;
            hi_r <= 8'h00;
            hi_ok_r <= 1'b0;
            rw_r <= 1'b0;
            lo_sel_r <= 1'b0;
            rd_word_r <= 16'h0000;
            wr_stb_r <= 1'b0;
            wr_addr_r <= 8'h00;
            wr_data_r <= 16'h0000;
            sda_o <= 1'b0;
            sda_oe_o <= 1'b0;
        end else begin
            wr_stb_r <= 1'b0;
            sda_o <= 1'b0;
            if (i2c_start) begin
                st_r <= ST_RX;
                kind_r <= K_ADDR;
                cnt_r <= 4'h0;
                hi_ok_r <= 1'b0;
                sda_oe_o <= 1'b0;
            end else if (i2c_stop) begin
                st_r <= ST_IDLE;
                hi_ok_r <= 1'b0;
                sda_oe_o <= 1'b0;
            end else begin
                case (st_r)
                    ST_RX: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sda_s_r};
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall && cnt_r == 4'h8) begin
                            cnt_r <= 4'h0;
                            st_r <= ST_ACK;
                            sda_oe_o <= 1'b1;
                            case (kind_r)
                                K_ADDR: begin
                                    if (shift_r[7:1] != `FGR_I2C_ADDR) begin
                                        st_r <= ST_IDLE;
                                        sda_oe_o <= 1'b0;
                                    end else begin
                                        rw_r <= shift_r[0];
                                        kind_r <= K_PTR;
                                    end
                                end
                                K_PTR: begin
                                    ptr_r <= shift_r;
                                    kind_r <= K_DATA;
                                end
                                default: begin
                                    if (!hi_ok_r) begin
                                        hi_r <= shift_r;
                                        hi_ok_r <= 1'b1;
                                    end else begin
                                        // Commit only a complete word
                                        hi_ok_r <= 1'b0;
                                        wr_stb_r <= 1'b1;
                                        wr_addr_r <= ptr_r;
                                        wr_data_r <= {hi_r, shift_r};
                                        ptr_r <= ptr_r + 8'h02;
                                        if (ptr_r == `FGR_OFS_CMDW
                                            && {hi_r, shift_r} == `FGR_POR_KEY) begin
                                            st_r <= ST_IDLE;
                                            sda_oe_o <= 1'b0;
                                        end
                                    end
                                end
                            endcase
                        end
                    end
                    ST_ACK: begin
                        if (scl_fall) begin
                            if (rw_r) begin
                                st_r <= ST_TX;
                                rd_word_r <= rd_word;
                                txs_r <= rd_word[15:8];
                                sda_oe_o <= ~rd_word[15];
                                lo_sel_r <= 1'b1;
                            end else begin
                                st_r <= ST_RX;
                                sda_oe_o <= 1'b0;
                            end
                        end
                    end
                    ST_TX: begin
                        if (scl_rise) begin
                            cnt_r <= cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            if (cnt_r == 4'h8) begin
                                cnt_r <= 4'h0;
                                st_r <= ST_RACK;
                                sda_oe_o <= 1'b0;
                            end else begin
                                txs_r <= {txs_r[6:0], 1'b0};
                                sda_oe_o <= ~txs_r[6];
                            end
                        end
                    end
                    ST_RACK: begin
                        if (scl_rise) begin
                            st_r <= sda_s_r ? ST_IDLE : ST_NEXT;
                            if (!lo_sel_r) begin
                                ptr_r <= ptr_r + 8'h02;
                            end
                        end
                    end
                    ST_NEXT: begin
                        if (scl_fall) begin
                            st_r <= ST_TX;
                            if (lo_sel_r) begin
                                txs_r <= rd_word_r[7:0];
                                sda_oe_o <= ~rd_word_r[7];
                                lo_sel_r <= 1'b0;
                            end else begin
                                rd_word_r <= rd_word;
                                txs_r <= rd_word[15:8];
                                sda_oe_o <= ~rd_word[15];
                                lo_sel_r <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        st_r <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Battery model table, write-only, no reset needed
    always @(posedge clk_i) begin
        if (wr_stb_r && wr_addr_r[7:6] == `FGR_TBL_BASE) begin
            tbl_r[wr_addr_r[5:1]] <= wr_data_r;
        end
    end

    // Hardware alert events; set wins over a software clear
    always @* begin
        stat_set = 16'h0000;
        if (vtick_r == 33'd0 && avg_ok_r) begin
            if (avg_r[15:8] > vwin_r[7:0]) begin
                stat_set[`FGR_ST_VH] = 1'b1;
            end
            if (avg_r[15:8] < vwin_r[15:8]) begin
                stat_set[`FGR_ST_VL] = 1'b1;
            end
        end
        if (soc_valid_i && soc_ok_r) begin
            if (soc_r[15:8] >= hd_thr && soc_i[15:8] < hd_thr) begin
                stat_set[`FGR_ST_HD] = 1'b1;
            end
            if (setup_r[`FGR_SET_ALSC] && soc_i[15:8] != soc_ref_r) begin
                stat_set[`FGR_ST_SC] = 1'b1;
            end
        end
        if (reset_voltage_event_i) begin
            stat_set[`FGR_ST_VR] = 1'b1;
        end
        stat_nxt = stat_r;
        setup_nxt = setup_r;
        if (wr_stb_r && wr_addr_r == `FGR_OFS_STAT) begin
            stat_nxt = wr_data_r;
        end
        if (wr_stb_r && wr_addr_r == `FGR_OFS_SETUP) begin
            setup_nxt = wr_data_r;
        end
        stat_nxt = stat_nxt | stat_set;
        if ((stat_set & 16'h0036) != 16'h0000
            || (stat_set[`FGR_ST_VR] && stat_r[`FGR_ST_ENVR])) begin
            setup_nxt[`FGR_SET_ALERT] = 1'b1;
        end
    end

    // Register file and measurement path
    always @(posedge clk_i) begin
        if (rst_all) begin
            cellv_r <= 16'h0000;
            soc_r <= 16'h0000;
            rate_r <= 16'h0000;
            mode_r <= `FGR_RST_MODE;
            hibthr_r <= `FGR_RST_HIBTHR;
            setup_r <= `FGR_RST_SETUP;
            vwin_r <= `FGR_RST_VWIN;
            vrst_r <= `FGR_RST_VRST;
            stat_r <= `FGR_RST_STAT;
            cmd_r <= `FGR_RST_CMD;
            acc_r <= 18'h00000;
            nacc_r <= 2'h0;
            avg_r <= 16'h0000;
            avg_ok_r <= 1'b0;
            vtick_r <= 33'd0;
            boot_r <= 33'd0;
            soc_ok_r <= 1'b0;
            soc_ref_r <= 8'h00;
            quick_start_o <= 1'b0;
            sleep_en_o <= 1'b0;
            sleep_force_o <= 1'b0;
            reset_voltage_threshold_o <= `FGR_RST_VRST;
            alert_output_flag_n_o <= 1'b1;
        end else begin
            quick_start_o <= 1'b0;
            // Four-sample mean; sum kept wide to avoid overflow
            if (adc_valid_i) begin
                nacc_r <= nacc_r + 2'h1;
                if (nacc_r == 2'h3) begin
                    avg_r <= acc_r[17:2] + {2'h0, adc_data_i[15:2]};
                    acc_r <= 18'h00000;
                    avg_ok_r <= 1'b1;
                end else begin
                    acc_r <= acc_r + {2'h0, adc_data_i};
                end
            end
            if (vtick_r == 33'd0) begin
                vtick_r <= vper - 33'd1;
                if (avg_ok_r) begin
                    cellv_r <= avg_r;
                end
            end else if (vtick_r >= vper) begin
                vtick_r <= vper - 33'd1;
            end else begin
                vtick_r <= vtick_r - 33'd1;
            end
            if (!soc_ok_r) begin
                boot_r <= boot_r + 33'd1;
                if (boot_r >= SOC_FIRST_CYC - 33'd1) begin
                    soc_ok_r <= 1'b1;
                end
            end
            if (soc_valid_i && soc_ok_r) begin
                soc_r <= soc_i;
                if (stat_set[`FGR_ST_SC]) begin
                    soc_ref_r <= soc_i[15:8];
                end
            end
            if (charge_rate_valid_i) begin
                rate_r <= charge_rate_estimate_i;
            end
            stat_r <= stat_nxt;
            setup_r <= setup_nxt;
            if (wr_stb_r) begin
                case (wr_addr_r)
                    `FGR_OFS_MODE: begin
                        mode_r <= wr_data_r & 16'h6000;
                        quick_start_o <= wr_data_r[`FGR_MODE_QSTRT];
                    end
                    `FGR_OFS_HIBTHR: hibthr_r <= wr_data_r;
                    `FGR_OFS_VWIN: vwin_r <= wr_data_r;
                    `FGR_OFS_VRST: vrst_r <= wr_data_r[15:8];
                    `FGR_OFS_CMDW: cmd_r <= wr_data_r;
                    default: ;
                endcase
            end
            sleep_en_o <= mode_r[`FGR_MODE_ENSLP];
            sleep_force_o <= mode_r[`FGR_MODE_ENSLP] & setup_r[`FGR_SET_SLEEP];
            reset_voltage_threshold_o <= vrst_r;
            alert_output_flag_n_o <= ~setup_r[`FGR_SET_ALERT];
        end
    end

endmodule // fgr_regbank
`default_nettype wire

// >>> shared/fgr_map.vh
// Fuel-gauge register bank: offsets, fields, reset values, timing
`ifndef FGR_MAP_VH
`define FGR_MAP_VH

`define FGR_I2C_ADDR 7'h36
`define FGR_OFS_CELLV 8'h02
`define FGR_OFS_SOC 8'h04
`define FGR_OFS_MODE 8'h06
`define FGR_OFS_VER 8'h08
`define FGR_OFS_HIBTHR 8'h0A
`define FGR_OFS_SETUP 8'h0C
`define FGR_OFS_VWIN 8'h14
`define FGR_OFS_RATE 8'h16
`define FGR_OFS_VRST 8'h18
`define FGR_OFS_STAT 8'h1A
`define FGR_OFS_CMD 8'h3E
`define FGR_OFS_CMDW 8'hFE
`define FGR_TBL_BASE 2'h1

`define FGR_RST_MODE 16'h0000
`define FGR_RST_HIBTHR 16'h8030
`define FGR_RST_SETUP 16'h971C
`define FGR_RST_VWIN 16'h00FF
`define FGR_RST_VRST 8'h96
`define FGR_RST_STAT 16'h0001
`define FGR_RST_CMD 16'hFFFF
`define FGR_POR_KEY 16'h5400

// Mode word fields
`define FGR_MODE_QSTRT 14
`define FGR_MODE_ENSLP 13
`define FGR_MODE_HIB 12
// Setup word fields
`define FGR_SET_SLEEP 7
`define FGR_SET_ALSC 6
`define FGR_SET_ALERT 5
// Alert flag fields
`define FGR_ST_RI 0
`define FGR_ST_VH 1
`define FGR_ST_VL 2
`define FGR_ST_VR 3
`define FGR_ST_HD 4
`define FGR_ST_SC 5
`define FGR_ST_ENVR 14

`define FGR_CLK_HZ 33'd100000000
`define FGR_VACT_MS 33'd250
`define FGR_VHIB_S 33'd45
`define FGR_SOC_FIRST_S 33'd1

`endif
